// File: dv/sebw_master.sv
module sebw_master (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------
  // two-wire master, open-drain data
  // ---------------------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start;
    sda_low = 1'b0;
    hc(2);
    scl = 1'b1;
    hc(4);
    sda_low = 1'b1;
    hc(4);
    scl = 1'b0;
    hc(2);
  endtask

  task automatic stop;
    sda_low = 1'b1;
    hc(2);
    scl = 1'b1;
    hc(4);
    sda_low = 1'b0;
    hc(4);
  endtask

  // high sample at either point reads as high
  task automatic xfer_bit(input logic v, output logic s);
    logic s0;
    sda_low = ~v;
    hc(2);
    scl = 1'b1;
    hc(1);
    s0 = sda;
    hc(2);
    s = s0 | sda;
    hc(1);
    scl = 1'b0;
    hc(2);
  endtask

  task automatic xfer_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], s);
    end
    xfer_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule // sebw_master

// File: dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // device type: value is arbitrary
  localparam logic [3:0] TYPE = 4'h6;
  localparam logic [2:0] CS = 3'h5;
  localparam int WC = 200;
  localparam logic [7:0] CW = {TYPE, CS, 1'b0};

  logic clk = 1'b0;
  logic rst_n, wp, scl, sda_low, sda, sda_out, sda_oe, busy, bus_idle, rd_start, mem_we;
  logic [2:0] cs_pins;
  logic [12:0] addr_ptr, mem_addr;
  logic [7:0] mem_wdata;
  logic [20:0] wq[$];
  int error_cnt, checks, cyc, rd_cnt;
  int busy_len, busy_last;

  always #10 clk = ~clk;
  // pull-up on the data wire
  assign sda = ~(sda_low | (sda_oe & ~sda_out));

  sebw_top #(.DEV_TYPE(TYPE), .WRITE_CYCLES(WC)) dut (
    .CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .CHIP_SEL(cs_pins), .WP(wp), .BUSY(busy), .BUS_IDLE(bus_idle), .RD_START(rd_start),
    .ADDR_PTR(addr_ptr), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata)
  );

  sebw_master m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));

  // ---------------------------------
  // monitor and timeout
  // ---------------------------------
  // outputs are looked at mid-cycle, where they are settled
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (mem_we === 1'b1) wq.push_back({mem_addr, mem_wdata});
    if (rd_start === 1'b1) rd_cnt <= rd_cnt + 1;
    if (busy === 1'b1) busy_len <= busy_len + 1;
    else if (busy_len != 0) begin
      busy_last <= busy_len;
      busy_len <= 0;
    end
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH at %0t: timeout", $time);
      wrap_up;
    end
  end

  // ---------------------------------
  // helpers
  // ---------------------------------
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic exp);
    logic a;
    m.xfer_byte(b, a);
    chk(a, exp, "ack");
  endtask

  task automatic wait_free;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(n <= WC + 4, 1'b1, "write time");
    chk(busy, 1'b0, "busy end");
    @(negedge clk);
    chk(busy_last, WC, "busy length");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_idle;
    chk(bus_idle, 1'b1, "idle");
    chk(sda_oe, 1'b0, "released");
    chk(busy, 1'b0, "busy");
    $display("test idle done");
  endtask

  task automatic t_select;
    m.start;
    wb({4'h9, CS, 1'b0}, 1'b0);
    wb(8'h00, 1'b0);
    m.stop;
    for (int k = 0; k < 3; k++) begin
      m.start;
      wb({TYPE, CS ^ (3'h1 << k), 1'b0}, 1'b0);
      m.stop;
    end
    $display("test select done");
  endtask

  task automatic t_byte;
    wq.delete();
    m.start;
    wb(CW, 1'b1);
    wb(8'hE3, 1'b1);
    wb(8'h1F, 1'b1);
    wb(8'hA5, 1'b1);
    chk(wq.size(), 0, "early write");
    m.stop;
    wp = 1'b1;
    chk(busy, 1'b1, "busy");
    m.start;
    wb(CW, 1'b0);
    m.stop;
    wait_free;
    wp = 1'b0;
    chk(wq.size(), 1, "count");
    chk(wq[0], {13'h031F, 8'hA5}, "write");
    chk(addr_ptr, 13'h0300, "ptr");
    m.start;
    wb(CW, 1'b1);
    m.stop;
    wait_free;
    $display("test byte done");
  endtask

  task automatic t_page;
    wq.delete();
    m.start;
    wb(CW, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h40, 1'b1);
    for (int i = 0; i < 34; i++) begin
      wb(8'(i), 1'b1);
    end
    m.stop;
    wait_free;
    chk(wq.size(), 32, "count");
    for (int k = 0; k < 32; k++) begin
      chk(wq[k], {13'h0040 | 13'(k), k < 2 ? 8'(32 + k) : 8'(k)}, "slot");
    end
    chk(addr_ptr, 13'h0042, "ptr");
    $display("test page done");
  endtask

  task automatic t_wp;
    wq.delete();
    wp = 1'b1;
    m.start;
    wb(CW, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h5A, 1'b1);
    m.stop;
    wp = 1'b0;
    chk(busy, 1'b0, "busy");
    m.start;
    wb(CW, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h20, 1'b1);
    m.stop;
    repeat (8) @(negedge clk);
    chk(wq.size(), 0, "protected");
    chk(addr_ptr, 13'h0020, "ptr");
    wait_free;
    $display("test protect done");
  endtask

  task automatic t_read;
    logic s;
    m.start;
    wb({TYPE, CS, 1'b1}, 1'b1);
    m.xfer_bit(1'b1, s);
    chk(s, 1'b1, "released");
    m.stop;
    chk(rd_cnt, 1, "read start");
    $display("test read done");
  endtask

  task automatic t_abort;
    logic s;
    wq.delete();
    m.start;
    repeat (3) m.xfer_bit(1'b1, s);
    m.start;
    wb(CW, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h08, 1'b1);
    m.stop;
    repeat (8) @(negedge clk);
    chk(wq.size(), 0, "no write");
    chk(addr_ptr, 13'h0008, "ptr");
    chk(bus_idle, 1'b1, "idle");
    // stop cut into an address byte
    m.start;
    wb(CW, 1'b1);
    repeat (3) m.xfer_bit(1'b0, s);
    m.stop;
    chk(busy, 1'b0, "cut byte");
    m.start;
    wb(CW, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h08, 1'b1);
    wb(8'h77, 1'b1);
    // repeated start drops the buffered page
    m.start;
    m.stop;
    repeat (8) @(negedge clk);
    chk(wq.size(), 0, "dropped page");
    chk(busy, 1'b0, "no cycle");
    chk(addr_ptr, 13'h0009, "ptr");
    $display("test abort done");
  endtask

  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    cs_pins = CS;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    rd_cnt = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_idle;
    t_select;
    t_byte;
    t_page;
    t_wp;
    t_read;
    t_abort;
    wrap_up;
  end
endmodule // tb_top

// File: hdl/sebw_page_buf.sv
module sebw_page_buf (
  input wire logic clk,
  input wire logic rst_n,
  sebw_buf_if.mem bus
);
  logic [7:0] mem_reg [sebw_pkg::PAGE_BYTES];
  logic [7:0] rdata_reg;

  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem_reg[bus.waddr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= mem_reg[bus.raddr];
    end
  end

  assign bus.rdata = rdata_reg;
endmodule // sebw_page_buf

// File: hdl/sebw_sync.sv
module sebw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // sebw_sync

// File: hdl/sebw_top.sv
module sebw_top #(
  parameter logic [3:0] DEV_TYPE = sebw_pkg::DEV_TYPE_DFLT,
  parameter int unsigned WRITE_CYCLES = sebw_pkg::TWC_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [2:0] CHIP_SEL,
  input wire logic WP,
  output logic BUSY,
  output logic BUS_IDLE,
  output logic RD_START,
  output logic [sebw_pkg::ADDR_W-1:0] ADDR_PTR,
  output logic MEM_WE,
  output logic [sebw_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA
);
  localparam int CW = $clog2(WRITE_CYCLES + 1);

  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  logic [1:0] line_s;
  logic [3:0] pins_s;
  logic s_scl;
  logic s_sda;
  logic wp_s;
  logic [2:0] cs_s;
  logic scl_d_reg;
  logic sda_d_reg;

  sebw_sync #(.W(2), .RST_VAL(2'h3)) u_sync_line (
    .clk(CLK),
    .rst_n(RST_N),
    .d({SCL, SDA_IN}),
    .q(line_s)
  );

  sebw_sync #(.W(4), .RST_VAL(4'h0)) u_sync_pins (
    .clk(CLK),
    .rst_n(RST_N),
    .d({WP, CHIP_SEL}),
    .q(pins_s)
  );

  assign s_scl = line_s[1];
  assign s_sda = line_s[0];
  assign wp_s = pins_s[3];
  assign cs_s = pins_s[2:0];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= s_scl;
      sda_d_reg <= s_sda;
    end
  end

  wire scl_rise = s_scl && !scl_d_reg;
  wire scl_fall = !s_scl && scl_d_reg;
  wire start_det = s_scl && scl_d_reg && sda_d_reg && !s_sda; // [RULE_02]
  wire stop_det = s_scl && scl_d_reg && !sda_d_reg && s_sda; // [RULE_03]
  wire frame_cut = start_det || stop_det;

  // ----------------------------------------
  // state and bit counting
  // ----------------------------------------
  sebw_pkg::sebw_state_t state_reg;
  sebw_pkg::sebw_state_t state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic busy_reg;

  wire rx_active = (state_reg == sebw_pkg::ST_CTRL) || (state_reg == sebw_pkg::ST_ADDR_HI) ||
                   (state_reg == sebw_pkg::ST_ADDR_LO) || (state_reg == sebw_pkg::ST_DATA);
  wire bit_take = scl_rise && rx_active && (bit_cnt_reg < sebw_pkg::BIT_ACK); // [RULE_04]
  wire byte_done = scl_fall && rx_active && (bit_cnt_reg == sebw_pkg::BIT_ACK);
  wire ack_end = scl_fall && (bit_cnt_reg == sebw_pkg::BIT_END); // [RULE_06]

  // control byte fields
  wire [3:0] ctrl_type = shift_reg[7:sebw_pkg::CTRL_TYPE_LSB]; // [RULE_10]
  wire [2:0] ctrl_cs = shift_reg[sebw_pkg::CTRL_TYPE_LSB-1:sebw_pkg::CTRL_CS_LSB];
  wire ctrl_rd = shift_reg[sebw_pkg::CTRL_RW_BIT]; // [RULE_12]
  wire ctrl_match = (ctrl_type == DEV_TYPE) && (ctrl_cs == cs_s); // [RULE_11]
  wire in_ctrl_done = byte_done && (state_reg == sebw_pkg::ST_CTRL);
  wire ctrl_take = in_ctrl_done && ctrl_match && !busy_reg; // [RULE_07] [RULE_23]
  wire ctrl_wr_ok = ctrl_take && !ctrl_rd;
  wire ctrl_rd_ok = ctrl_take && ctrl_rd;

  always_comb begin
    state_next = state_reg;
    if (start_det) begin
      state_next = sebw_pkg::ST_CTRL; // [RULE_02]
    end else if (stop_det) begin
      state_next = sebw_pkg::ST_IDLE; // [RULE_03]
    end else if (byte_done) begin
      case (state_reg)
        sebw_pkg::ST_CTRL: begin
          if (!ctrl_take) begin
            state_next = sebw_pkg::ST_IGNORE; // [RULE_24]
          end else if (ctrl_rd) begin
            state_next = sebw_pkg::ST_READ; // [RULE_12]
          end else begin
            state_next = sebw_pkg::ST_ADDR_HI; // [RULE_13]
          end
        end
        sebw_pkg::ST_ADDR_HI: state_next = sebw_pkg::ST_ADDR_LO;
        sebw_pkg::ST_ADDR_LO: state_next = sebw_pkg::ST_DATA;
        sebw_pkg::ST_DATA: state_next = sebw_pkg::ST_DATA; // [RULE_05]
        default: state_next = state_reg;
      endcase
    end
  end

  // idle waits for a start; a start in any other state also begins a transfer
  wire bus_idle_next = (state_next == sebw_pkg::ST_IDLE) && s_scl && s_sda; // [RULE_01]

  assign bit_cnt_next = frame_cut ? 4'h0 : // [RULE_25]
                        bit_take ? bit_cnt_reg + 4'h1 :
                        byte_done ? sebw_pkg::BIT_END :
                        ack_end ? 4'h0 : bit_cnt_reg;
  assign shift_next = start_det ? 8'h00 : bit_take ? {shift_reg[6:0], s_sda} : shift_reg; // [RULE_04]

  logic bus_idle_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg <= sebw_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      bus_idle_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      bus_idle_reg <= bus_idle_next;
    end
  end

  // ----------------------------------------
  // acknowledge driver
  // ----------------------------------------
  logic ack_reg;
  logic ack_next;
  logic rd_start_reg;
  wire addr_or_data = (state_reg == sebw_pkg::ST_ADDR_HI) || (state_reg == sebw_pkg::ST_ADDR_LO) ||
                      (state_reg == sebw_pkg::ST_DATA);
  // ignore and read states never set it, so sda stays released there once the control byte acknowledge ends
  wire ack_set = ctrl_take || (byte_done && addr_or_data && !busy_reg); // [RULE_06] [RULE_14] [RULE_15]

  // held from the falling edge after bit eight to the end of the ninth pulse
  assign ack_next = frame_cut ? 1'b0 : ack_set ? 1'b1 : ack_end ? 1'b0 : ack_reg; // [RULE_08] [RULE_09]

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
      rd_start_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      rd_start_reg <= ctrl_rd_ok;
    end
  end

  // ----------------------------------------
  // address pointer and page buffer
  // ----------------------------------------
  logic [sebw_pkg::ADDR_W-1:0] ptr_reg;
  logic [sebw_pkg::ADDR_W-1:0] ptr_next;
  logic [sebw_pkg::PAGE_BYTES-1:0] mask_reg;
  logic [sebw_pkg::PAGE_BYTES-1:0] mask_next;
  sebw_buf_if buf_if ();

  wire hi_take = byte_done && (state_reg == sebw_pkg::ST_ADDR_HI);
  wire lo_take = byte_done && (state_reg == sebw_pkg::ST_ADDR_LO);
  wire data_take = byte_done && (state_reg == sebw_pkg::ST_DATA);
  wire [sebw_pkg::PAGE_W-1:0] ptr_low_inc = ptr_reg[sebw_pkg::PAGE_W-1:0] + 5'h01;
  wire got_data = |mask_reg;

  // upper three address bits dropped, 13-bit pointer cannot leave the array
  assign ptr_next = hi_take ? {shift_reg[sebw_pkg::ADDR_HI_BITS-1:0], ptr_reg[7:0]} : // [RULE_13] [RULE_20]
                    lo_take ? {ptr_reg[sebw_pkg::ADDR_W-1:8], shift_reg} :
                    data_take ? {ptr_reg[sebw_pkg::ADDR_W-1:sebw_pkg::PAGE_W], ptr_low_inc} : // [RULE_16] [RULE_18]
                    ptr_reg;
  // a wrapped byte lands on an earlier slot and replaces it
  assign mask_next = ctrl_wr_ok ? sebw_pkg::MASK_RST :
                     data_take ? (mask_reg | (32'h00000001 << ptr_reg[sebw_pkg::PAGE_W-1:0])) : // [RULE_18]
                     mask_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ptr_reg <= sebw_pkg::PTR_RST;
      mask_reg <= sebw_pkg::MASK_RST;
    end else begin
      ptr_reg <= ptr_next;
      mask_reg <= mask_next;
    end
  end

  assign buf_if.we = data_take; // [RULE_17]
  assign buf_if.waddr = ptr_reg[sebw_pkg::PAGE_W-1:0];
  assign buf_if.wdata = shift_reg;

  sebw_page_buf u_page_buf (
    .clk(CLK),
    .rst_n(RST_N),
    .bus(buf_if.mem)
  );

  // ----------------------------------------
  // self-timed write cycle
  // ----------------------------------------
  logic [CW-1:0] cyc_reg;
  logic [CW-1:0] cyc_next;
  logic [5:0] idx_reg;
  logic [5:0] idx_next;
  logic busy_next;
  logic [sebw_pkg::ADDR_W-sebw_pkg::PAGE_W-1:0] page_reg;
  logic mem_we_reg;
  logic [sebw_pkg::ADDR_W-1:0] mem_addr_reg;
  logic [7:0] mem_wdata_reg;

  // protect level taken only at the stop; later changes are not looked at
  wire stop_write = stop_det && (state_reg == sebw_pkg::ST_DATA) && got_data; // [RULE_14] [RULE_17]
  wire commit_go = stop_write && !wp_s; // [RULE_15] [RULE_19]
  wire cyc_last = (cyc_reg == CW'(WRITE_CYCLES - 1));
  wire idx_run = busy_reg && (idx_reg <= sebw_pkg::COMMIT_END);
  wire [5:0] idx_m1 = idx_reg - 6'h01;
  wire [sebw_pkg::PAGE_W-1:0] wr_slot = idx_m1[sebw_pkg::PAGE_W-1:0];
  wire wr_ok = idx_run && (idx_reg != 6'h00) && mask_reg[wr_slot];

  assign busy_next = commit_go ? 1'b1 : (busy_reg && cyc_last) ? 1'b0 : busy_reg; // [RULE_22]
  assign cyc_next = commit_go ? '0 : busy_reg ? cyc_reg + CW'(1) : cyc_reg;
  assign idx_next = commit_go ? 6'h00 : idx_run ? idx_reg + 6'h01 : idx_reg;
  assign buf_if.raddr = idx_reg[sebw_pkg::PAGE_W-1:0];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      busy_reg <= 1'b0;
      cyc_reg <= '0;
      idx_reg <= sebw_pkg::COMMIT_DONE;
      page_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      cyc_reg <= cyc_next;
      idx_reg <= idx_next;
      page_reg <= commit_go ? ptr_reg[sebw_pkg::ADDR_W-1:sebw_pkg::PAGE_W] : page_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mem_we_reg <= 1'b0;
      mem_addr_reg <= sebw_pkg::PTR_RST;
      mem_wdata_reg <= 8'h00;
    end else begin
      mem_we_reg <= wr_ok; // [RULE_17]
      mem_addr_reg <= {page_reg, wr_slot};
      mem_wdata_reg <= buf_if.rdata;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign SDA_OUT = 1'b0;
  assign SDA_OE = ack_reg;
  assign BUSY = busy_reg;
  assign BUS_IDLE = bus_idle_reg;
  assign RD_START = rd_start_reg;
  assign ADDR_PTR = ptr_reg;
  assign MEM_WE = mem_we_reg;
  assign MEM_ADDR = mem_addr_reg;
  assign MEM_WDATA = mem_wdata_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_NO_ACK_BUSY: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_07]
    busy_reg |-> !ack_reg)
    else $error("acknowledge driven during write cycle");

  AST_START_RESET: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_25]
    start_det |=> (bit_cnt_reg == 4'h0) && (state_reg == sebw_pkg::ST_CTRL) && !ack_reg)
    else $error("start did not restart byte");

  AST_STOP_IDLE: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_03]
    stop_det |=> (state_reg == sebw_pkg::ST_IDLE) && (bit_cnt_reg == 4'h0))
    else $error("stop did not return to idle");

  AST_ACK_HOLD: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_08]
    ack_reg && s_scl && !frame_cut |=> ack_reg)
    else $error("acknowledge released while clock high");

  AST_CTRL_MISS: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_11]
    in_ctrl_done && !ctrl_match && !frame_cut |=> !ack_reg && (state_reg == sebw_pkg::ST_IGNORE))
    else $error("mismatching control byte answered");

  AST_IGNORE_QUIET: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_24]
    (state_reg == sebw_pkg::ST_IGNORE) && !start_det |=> !ack_reg)
    else $error("sda driven while ignoring");

  AST_WP_SKIP: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_15]
    stop_write && wp_s |=> !busy_reg ##1 !MEM_WE)
    else $error("protected write started a cycle");

  AST_BUSY_START: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_14]
    stop_write && !wp_s |=> busy_reg && (cyc_reg == '0))
    else $error("stop did not start write cycle");

  AST_PTR_WRAP: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_18]
    data_take && !frame_cut |=>
      (ptr_reg[4:0] == $past(ptr_low_inc)) && (ptr_reg[12:5] == $past(ptr_reg[12:5])))
    else $error("page pointer did not step in page");

  AST_BUSY_END: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_22]
    busy_reg && cyc_last |=> !busy_reg)
    else $error("write cycle overran");

  AST_BUSY_KEEP: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_22]
    busy_reg && !cyc_last |=> busy_reg)
    else $error("write cycle ended early");

  AST_MEM_IN_CYCLE: assert property (@(posedge CLK) disable iff (!RST_N) // [RULE_17]
    MEM_WE |-> $past(busy_reg))
    else $error("array written outside write cycle");
endmodule // sebw_top

// File: include/sebw_buf_if.sv
interface sebw_buf_if;
  logic we;
  logic [sebw_pkg::PAGE_W-1:0] waddr;
  logic [7:0] wdata;
  logic [sebw_pkg::PAGE_W-1:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: include/sebw_pkg.sv
// What this block does
// [RULE_01] both lines high means bus idle
// [RULE_02] sda falling with scl high is start
// [RULE_03] sda rising with scl high is stop
// [RULE_04] bits sampled while scl high, one per pulse
// [RULE_05] master chooses byte count per transfer
// [RULE_06] ninth clock carries receiver acknowledge
// [RULE_07] no acknowledge during programming cycle
// [RULE_08] acknowledge holds sda low through high phase
// [RULE_09] after master nack, sda stays released
// [RULE_10] control byte: type, three selects, direction
// [RULE_11] acknowledge only matching type and selects
// [RULE_12] direction bit one reads, zero writes
// [RULE_13] two address bytes, high first, 13 bits
// [RULE_14] byte write acks all, stop starts cycle
// [RULE_15] protected write acks, stores nothing, stays ready
// [RULE_16] pointer ends one past last written byte
// [RULE_17] page bytes buffered, committed after stop
// [RULE_18] low five pointer bits wrap in page
// [RULE_19] protect pin sampled at stop only
// [RULE_20] address counter stays inside own array
// [RULE_21] master may use selects as high address
// [RULE_22] write cycle ends within five milliseconds
// [RULE_23] after cycle, matching control byte acked again
// [RULE_24] mismatch ignores bus until next start
// [RULE_25] start or stop mid-byte resets counters
package sebw_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TWC_MS = 5;
  // longest time, so rounded down
  localparam int unsigned TWC_CYCLES = (CLK_HZ / 1000) * TWC_MS;
  // device type code: value is arbitrary
  localparam logic [3:0] DEV_TYPE_DFLT = 4'h5;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned PAGE_W = 5;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned CTRL_RW_BIT = 0;
  localparam int unsigned CTRL_CS_LSB = 1;
  localparam int unsigned CTRL_TYPE_LSB = 4;
  localparam int unsigned ADDR_HI_BITS = 5;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [5:0] COMMIT_END = 6'h20;
  localparam logic [5:0] COMMIT_DONE = 6'h21;
  localparam logic [ADDR_W-1:0] PTR_RST = 13'h0000;
  localparam logic [PAGE_BYTES-1:0] MASK_RST = 32'h00000000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CTRL = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_DATA = 3'b100,
    ST_READ = 3'b101,
    ST_IGNORE = 3'b110
  } sebw_state_t;
endpackage
